// >>> src/power_fault_irq.sv
// power-fault interrupt flags, enables, irq gating, return stack and scratch
// assumes one 50 MHz clock, synchronous active-low reset, fault inputs in aclk domain
`timescale 1ns/1ps
`include "pwr_consts.svh"
module power_fault_irq (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input pwr_pkg::addr_t awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output pwr_pkg::resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input pwr_pkg::addr_t araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output pwr_pkg::resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  // fault comparators
  input wire logic uv_fault,
  input wire logic oc_fault,
  input wire logic ov_fault,
  input wire logic supply_low,
  // interrupt outputs
  output logic core_irq,
  output logic irq_out,
  // core context
  input wire logic irq_take,
  input wire logic irq_return,
  input pwr_pkg::pc_t core_pc,
  output pwr_pkg::pc_t ret_pc_ff,
  input pwr_pkg::ram_addr_t ram_addr,
  input wire logic ram_wr,
  input pwr_pkg::byte_t ram_wdata,
  input wire logic swap_op,
  output pwr_pkg::byte_t ram_rdata,
  input wire logic alu_flags_we,
  input wire logic [2:0] alu_flags,
  output logic [2:0] status_flags_ff
);
  import pwr_pkg::*;

  // ==========================================================
  // axi write channel
  logic aw_got_ff, w_got_ff, bvalid_ff;
  addr_t awaddr_ff;
  byte_t wbyte_ff;
  logic wlane_ff;
  resp_t bresp_ff;
  logic aw_take, w_take, have_aw, have_w, wr_fire, wr_en, wr_ok;
  addr_t wa;
  byte_t wb;
  logic wl;

  assign awready = !aw_got_ff && !bvalid_ff;
  assign wready = !w_got_ff && !bvalid_ff;
  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign have_aw = aw_got_ff || aw_take;
  assign have_w = w_got_ff || w_take;
  assign wr_fire = have_aw && have_w;
  assign wa = aw_got_ff ? awaddr_ff : awaddr;
  assign wb = w_got_ff ? wbyte_ff : wdata[7:0];
  assign wl = w_got_ff ? wlane_ff : wstrb[0];
  // registers are one byte wide: only lane 0 carries data
  assign wr_en = wr_fire && wl && wr_ok;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  always_comb begin
    case (wa)
      `OFF_FLAGS, `OFF_ENABLES, `OFF_CTRL, `OFF_EVT, `OFF_MASK, `OFF_STACK: begin
        wr_ok = 1'h1;
      end
      default: begin
        wr_ok = 1'h0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= `BIT_RST;
      w_got_ff <= `BIT_RST;
      awaddr_ff <= `OFF_FLAGS;
      wbyte_ff <= `BYTE_RST;
      wlane_ff <= `BIT_RST;
    end else if (wr_fire) begin
      aw_got_ff <= 1'h0;
      w_got_ff <= 1'h0;
    end else begin
      if (aw_take) begin
        aw_got_ff <= 1'h1;
        awaddr_ff <= awaddr;
      end
      if (w_take) begin
        w_got_ff <= 1'h1;
        wbyte_ff <= wdata[7:0];
        wlane_ff <= wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= `BIT_RST;
      bresp_ff <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'h1;
      bresp_ff <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'h0;
    end
  end

  // ==========================================================
  // fault flags
  logic uv_flag, oc_flag, ov_flag;
  byte_t flag_rd;
  logic flag_wr;

  assign flag_wr = wr_en && (wa == `OFF_FLAGS);

  fault_flag_cell u_uv (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_evt(uv_fault),
    .sw_wr(flag_wr),
    .sw_val(wb[`BIT_UV]),
    .flag_ff(uv_flag)
  );
  fault_flag_cell u_oc (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_evt(oc_fault),
    .sw_wr(flag_wr),
    .sw_val(wb[`BIT_OC]),
    .flag_ff(oc_flag)
  );
  fault_flag_cell u_ov (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_evt(ov_fault),
    .sw_wr(flag_wr),
    .sw_val(wb[`BIT_OV]),
    .flag_ff(ov_flag)
  );

  // lockout bit is a live status, not a latch; bits 6, 3, 2 and 0 are tied to zero
  always_comb begin
    flag_rd = `BYTE_RST;
    flag_rd[`BIT_UV] = uv_flag;
    flag_rd[`BIT_OC] = oc_flag;
    flag_rd[`BIT_OV] = ov_flag;
    flag_rd[`BIT_VIN] = supply_low;
  end

  // ==========================================================
  // enables and interrupt control
  byte_t enables_ff, ctrl_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enables_ff <= `BYTE_RST;
    end else if (wr_en && (wa == `OFF_ENABLES)) begin
      enables_ff <= wb & `FLAG_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `BYTE_RST;
    end else if (wr_en && (wa == `OFF_CTRL)) begin
      ctrl_ff <= wb & `CTRL_MASK;
    end
  end

  assign core_irq = ctrl_ff[`BIT_GIE] && ctrl_ff[`BIT_PERIPHERAL_GROUP_ENABLE] && |(flag_rd & enables_ff);

  // ==========================================================
  // event status, read-to-clear, and masked interrupt line
  byte_t evt_ff, mask_ff, evt_set;
  logic uv_d_ff, oc_d_ff, ov_d_ff, vin_d_ff;
  logic ar_take, evt_clr;

  // status records onsets, so a steady fault raises one event only
  always_comb begin
    evt_set = `BYTE_RST;
    evt_set[`BIT_UV] = uv_fault && !uv_d_ff;
    evt_set[`BIT_OC] = oc_fault && !oc_d_ff;
    evt_set[`BIT_OV] = ov_fault && !ov_d_ff;
    evt_set[`BIT_VIN] = supply_low && !vin_d_ff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uv_d_ff <= `BIT_RST;
      oc_d_ff <= `BIT_RST;
      ov_d_ff <= `BIT_RST;
      vin_d_ff <= `BIT_RST;
    end else begin
      uv_d_ff <= uv_fault;
      oc_d_ff <= oc_fault;
      ov_d_ff <= ov_fault;
      vin_d_ff <= supply_low;
    end
  end

  assign evt_clr = ar_take && (araddr == `OFF_EVT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_ff <= `BYTE_RST;
    end else if (evt_clr) begin
      evt_ff <= evt_set;
    end else begin
      evt_ff <= evt_ff | evt_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_ff <= `BYTE_RST;
    end else if (wr_en && (wa == `OFF_MASK)) begin
      mask_ff <= wb & `FLAG_MASK;
    end
  end

  assign irq_out = |(evt_ff & mask_ff);

  // ==========================================================
  // return stack: only the pc goes in, never working or status
  pc_t stack [0:7];
  sp_t sp_ff;

  always_ff @(posedge aclk) begin
    if (irq_take) begin
      stack[sp_ff] <= core_pc;
    end
  end

  // eight deep and circular: overflow silently overwrites the oldest entry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_ff <= `SP_RST;
      ret_pc_ff <= `PC_RST;
    end else if (irq_take) begin
      sp_ff <= sp_ff + `SP_STEP;
    end else if (irq_return) begin
      sp_ff <= sp_ff - `SP_STEP;
      ret_pc_ff <= stack[sp_ff - `SP_STEP];
    end
  end

  // ==========================================================
  // scratch and status flags
  logic ram_hit;

  common_scratch u_scr (
    .aclk(aclk),
    .aresetn(aresetn),
    .addr(ram_addr),
    .wr(ram_wr),
    .wdata(ram_wdata),
    .swap(swap_op),
    .rdata_ff(ram_rdata),
    .hit(ram_hit)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_flags_ff <= `ALU3_RST;
    end else if (alu_flags_we && !swap_op) begin
      status_flags_ff <= alu_flags;
    end
  end

  // ==========================================================
  // axi read channel
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  resp_t rresp_ff;
  byte_t rd_byte;
  logic rd_ok;

  assign arready = !rvalid_ff;
  assign ar_take = arvalid && arready;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  always_comb begin
    rd_ok = 1'h1;
    case (araddr)
      `OFF_FLAGS: rd_byte = flag_rd;
      `OFF_ENABLES: rd_byte = enables_ff;
      `OFF_CTRL: rd_byte = ctrl_ff;
      `OFF_EVT: rd_byte = evt_ff;
      `OFF_MASK: rd_byte = mask_ff;
      `OFF_STACK: rd_byte = {5'h00, sp_ff};
      default: begin
        rd_byte = `BYTE_RST;
        rd_ok = 1'h0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= `BIT_RST;
      rdata_ff <= `WORD_RST;
      rresp_ff <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'h1;
      rdata_ff <= {24'h00_0000, rd_byte};
      rresp_ff <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid_ff <= 1'h0;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_uv_set;
    uv_fault |=> flag_rd[`BIT_UV];
  endproperty
  a_uv_set: assert property (p_uv_set) else $error("uv flag not set");

  property p_oc_set;
    oc_fault && !enables_ff[`BIT_OC] |=> oc_flag;
  endproperty
  a_oc_set: assert property (p_oc_set) else $error("oc flag not set");

  property p_ov_set;
    ov_fault && !ctrl_ff[`BIT_GIE] |=> ov_flag;
  endproperty
  a_ov_set: assert property (p_ov_set) else $error("ov flag gated");

  property p_vin_read;
    ar_take && araddr == `OFF_FLAGS |=> rdata[`BIT_VIN] == $past(supply_low);
  endproperty
  a_vin_read: assert property (p_vin_read) else $error("lockout bit wrong");

  property p_unimpl;
    ar_take && araddr == `OFF_FLAGS |=> (rdata[7:0] & ~`FLAG_MASK) == 8'h00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("reserved bit set");

  property p_hold;
    uv_flag && !uv_fault && !flag_wr |=> uv_flag [*1] ##0 $stable(uv_flag);
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");

  property p_push;
    irq_take |=> sp_ff == $past(sp_ff) + `SP_STEP ##0 stack[$past(sp_ff)] == $past(core_pc);
  endproperty
  a_push: assert property (p_push) else $error("pc not stacked");

  property p_group;
    !ctrl_ff[`BIT_PERIPHERAL_GROUP_ENABLE] |-> !core_irq;
  endproperty
  a_group: assert property (p_group) else $error("irq without group enable");

  property p_irq;
    ctrl_ff[`BIT_GIE] && ctrl_ff[`BIT_PERIPHERAL_GROUP_ENABLE] && uv_flag && enables_ff[`BIT_UV] |-> core_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("core irq missing");

  property p_swap;
    alu_flags_we && swap_op |=> $stable(status_flags_ff);
  endproperty
  a_swap: assert property (p_swap) else $error("swap changed status");

  property p_common;
    ram_wr && ram_hit ##1 ram_addr == $past(ram_addr) && !swap_op
      |=> ram_rdata == $past(ram_wdata, 2);
  endproperty
  a_common: assert property (p_common) else $error("scratch readback wrong");
endmodule

// >>> common/pwr_consts.svh
// register map, field positions and reset values of the power-fault flag block
// assumes a byte-addressed AXI4-Lite slave with 8 address bits
`ifndef PWR_CONSTS_SVH
`define PWR_CONSTS_SVH
`define ADDR_W 8
`define PC_W 13
`define OFF_FLAGS 8'h00
`define OFF_ENABLES 8'h04
`define OFF_CTRL 8'h08
`define OFF_EVT 8'h0C
`define OFF_MASK 8'h10
`define OFF_STACK 8'h14
`define BIT_UV 7
`define BIT_OC 5
`define BIT_OV 4
`define BIT_VIN 1
`define BIT_GIE 7
`define BIT_PERIPHERAL_GROUP_ENABLE 6
`define FLAG_MASK 8'hB2
`define CTRL_MASK 8'hC0
`define BYTE_RST 8'h00
`define BIT_RST 1'h0
`define PC_RST 13'h0000
`define ALU3_RST 3'h0
`define WORD_RST 32'h0000_0000
`define SP_RST 3'h0
`define SP_STEP 3'h1
`define COMMON_HI 3'h7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> common/pwr_pkg.sv
// types shared by the power-fault flag block and its helpers
// assumes pwr_consts.svh is on the include path
`include "pwr_consts.svh"
package pwr_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`PC_W-1:0] pc_t;
  typedef logic [2:0] sp_t;
  typedef logic [1:0] resp_t;
  typedef logic [6:0] ram_addr_t;
endpackage

// >>> src/fault_flag_cell.sv
// one sticky fault flag bit
// assumes set and write strobes synchronous to aclk
`timescale 1ns/1ps
`include "pwr_consts.svh"
module fault_flag_cell (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // event and software write
  input wire logic set_evt,
  input wire logic sw_wr,
  input wire logic sw_val,
  // flag
  output logic flag_ff
);
  // the set wins over a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ff <= `BIT_RST;
    end else if (set_evt) begin
      flag_ff <= 1'h1;
    end else if (sw_wr) begin
      flag_ff <= sw_val;
    end
  end
endmodule

// >>> src/common_scratch.sv
// bank-common scratch bytes for software context save
// assumes core addresses within a bank are 7 bits wide
`timescale 1ns/1ps
`include "pwr_consts.svh"
module common_scratch (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // core access
  input pwr_pkg::ram_addr_t addr,
  input wire logic wr,
  input pwr_pkg::byte_t wdata,
  input wire logic swap,
  output pwr_pkg::byte_t rdata_ff,
  output logic hit
);
  import pwr_pkg::*;
  byte_t mem [0:15];
  // bank bits never reach here: the top 16 bytes are one physical store
  assign hit = (addr[6:4] == `COMMON_HI);
  always_ff @(posedge aclk) begin
    if (hit && wr) begin
      mem[addr[3:0]] <= wdata;
    end
  end
  // banked locations live elsewhere, so a miss reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_ff <= `BYTE_RST;
    end else if (!hit) begin
      rdata_ff <= `BYTE_RST;
    end else if (swap) begin
      rdata_ff <= {mem[addr[3:0]][3:0], mem[addr[3:0]][7:4]};
    end else begin
      rdata_ff <= mem[addr[3:0]];
    end
  end
endmodule

// >>> dv/fault_src_model.sv
// behavioural model of the analog fault comparators facing the flag block
// assumes the bench asks for comparator levels on aclk, one bit per comparator
`timescale 1ns/1ps
module fault_src_model (
  // clock
  input wire logic aclk,
  // bench request: {undervoltage, overcurrent, overvoltage, supply low}
  input wire logic [3:0] req,
  // comparator outputs
  output logic uv_fault,
  output logic oc_fault,
  output logic ov_fault,
  output logic supply_low
);
  // ==========================================================================
  // comparator outputs
  // one clock of lag stands in for the comparator's own synchroniser stage
  always_ff @(posedge aclk) begin
    {uv_fault, oc_fault, ov_fault, supply_low} <= req;
  end
endmodule

// >>> dv/testbench.sv
// self-checking bench for the power-fault interrupt block
// assumes the design files and fault_src_model are compiled before it
`timescale 1ns/1ps
`include "pwr_consts.svh"
module testbench;
  import pwr_pkg::*;
  // ==========================================================================
  // signals
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, core_irq, irq_out;
  logic uv, oc, ov, low, take, ret, ram_wr, swap_op, fwe;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, req;
  logic [2:0] alu_flags, st_flags;
  addr_t awaddr, araddr;
  resp_t bresp, rresp, rs;
  pc_t core_pc, ret_pc;
  pc_t pcs [3];
  ram_addr_t ram_addr;
  byte_t ram_wdata, ram_rdata, d, f, e, c;
  int n_mismatch, checked;

  power_fault_irq i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .uv_fault(uv), .oc_fault(oc), .ov_fault(ov), .supply_low(low),
    .core_irq(core_irq), .irq_out(irq_out), .irq_take(take), .irq_return(ret),
    .core_pc(core_pc), .ret_pc_ff(ret_pc), .ram_addr(ram_addr), .ram_wr(ram_wr),
    .ram_wdata(ram_wdata), .swap_op(swap_op), .ram_rdata(ram_rdata),
    .alu_flags_we(fwe), .alu_flags(alu_flags), .status_flags_ff(st_flags));

  fault_src_model i_src (.aclk(aclk), .req(req), .uv_fault(uv), .oc_fault(oc),
    .ov_fault(ov), .supply_low(low));

  // ==========================================================================
  // helpers
  function automatic logic exp_irq(input byte_t fl, input byte_t en, input byte_t ct);
    return ct[`BIT_GIE] & ct[`BIT_PERIPHERAL_GROUP_ENABLE] & (|(fl & en & `FLAG_MASK));
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wr(input addr_t a, input byte_t v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // no cycle count is assumed: only the watchdog ends a stuck wait
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'b0;
    #1;
  endtask

  task automatic rd(input addr_t a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata[7:0];
    rs = rresp;
    rready <= 1'b0;
    #1;
  endtask

  // fault line high for exactly one clock, then time for the flag to land
  task automatic pulse(input logic [3:0] v);
    @(posedge aclk);
    req <= v;
    @(posedge aclk);
    req <= 4'h0;
    repeat (3) @(posedge aclk);
    #1;
  endtask

  // one-cycle pulse on irq_take (sel 0) or irq_return (sel 1); an output
  // argument would only copy out after the pulse, so the bench nets are driven
  task automatic step(input bit sel);
    @(posedge aclk);
    if (sel) begin
      ret <= 1'b1;
    end else begin
      take <= 1'b1;
    end
    @(posedge aclk);
    ret <= 1'b0;
    take <= 1'b0;
    #1;
  endtask

  // ==========================================================================
  // clock, watchdog
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    tally_and_finish();
  end

  // ==========================================================================
  // tests
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {take, ret, ram_wr, swap_op, fwe} = '0;
    {awaddr, araddr, wdata, req, alu_flags, core_pc, ram_addr, ram_wdata} = '0;
    wstrb = 4'hF;
    n_mismatch = 0;
    checked = 0;
    void'($urandom(32'hF519));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(addr_t'(4 * i));
      chk("reset value", d, 8'h00);
    end
    chk("irq at reset", core_irq, 1'b0);
    rd(8'h18);
    chk("unmapped read resp", rs, `RESP_SLVERR);
    wr(8'h40, 8'hFF);
    chk("unmapped write resp", rs, `RESP_SLVERR);
    // each fault sets only its own bit with every enable off, and stays set
    for (int k = 0; k < 3; k++) begin
      pulse(4'h8 >> k);
      rd(`OFF_FLAGS);
      chk("flag after fault", d, byte_t'(8'h80 >> (k == 0 ? 0 : k + 1)));
      wr(`OFF_FLAGS, 8'h00);
      rd(`OFF_FLAGS);
      chk("flag cleared", d, 8'h00);
    end
    // lockout status is live and unimplemented bits ignore writes
    @(posedge aclk);
    req <= 4'h1;
    wr(`OFF_FLAGS, 8'hFF);
    rd(`OFF_FLAGS);
    chk("flags all ones", d, 8'hB2);
    @(posedge aclk);
    req <= 4'h0;
    wr(`OFF_FLAGS, 8'h00);
    rd(`OFF_FLAGS);
    chk("flags lockout gone", d, 8'h00);
    // event status drives irq_out through the mask, read clears
    rd(`OFF_EVT);
    chk("event backlog", d, 8'hB2);
    wr(`OFF_MASK, 8'h80);
    pulse(4'h4);
    chk("masked event", irq_out, 1'b0);
    pulse(4'h8);
    chk("unmasked event", irq_out, 1'b1);
    rd(`OFF_EVT);
    chk("event status", d, 8'hA0);
    chk("event cleared", irq_out, 1'b0);
    // gating: four hand combinations of group and global, then random
    for (int i = 0; i < 16; i++) begin
      f = (i < 4) ? 8'h80 : byte_t'($urandom) & 8'hB0;
      e = (i < 4) ? 8'h80 : byte_t'($urandom) & 8'hB2;
      c = (i < 4) ? byte_t'(i << 6) : byte_t'($urandom) & 8'hC0;
      wr(`OFF_FLAGS, 8'h00);
      wr(`OFF_ENABLES, e);
      wr(`OFF_FLAGS, f);
      wr(`OFF_CTRL, c);
      chk("core irq", core_irq, exp_irq(f, e, c));
      rd(`OFF_ENABLES);
      chk("enables readback", d, e);
    end
    // lane 0 strobe off: answered okay, nothing stored
    wstrb <= 4'hE;
    wr(`OFF_ENABLES, ~e);
    chk("strobe-off resp", rs, `RESP_OKAY);
    wstrb <= 4'hF;
    rd(`OFF_ENABLES);
    chk("strobe-off kept", d, e);
    // entry stacks only the return address, popped last in first out
    for (int i = 0; i < 3; i++) begin
      pcs[i] = pc_t'($urandom);
      core_pc <= pcs[i];
      step(1'b0);
    end
    rd(`OFF_STACK);
    chk("stack depth", d, 8'h03);
    for (int i = 2; i >= 0; i--) begin
      step(1'b1);
      chk("return pc", ret_pc, pcs[i]);
    end
    // context save through the common bytes; swap leaves status alone
    @(posedge aclk);
    alu_flags <= 3'h5;
    fwe <= 1'b1;
    ram_addr <= 7'h7E;
    ram_wdata <= 8'h3C;
    ram_wr <= 1'b1;
    @(posedge aclk);
    ram_wr <= 1'b0;
    @(posedge aclk);
    #1;
    chk("plain read", ram_rdata, 8'h3C);
    alu_flags <= 3'h2;
    swap_op <= 1'b1;
    @(posedge aclk);
    @(posedge aclk);
    fwe <= 1'b0;
    swap_op <= 1'b0;
    ram_addr <= 7'h20;
    #1;
    chk("status kept", st_flags, 3'h5);
    chk("swapped read", ram_rdata, 8'hC3);
    @(posedge aclk);
    @(posedge aclk);
    #1;
    chk("banked miss", ram_rdata, 8'h00);
    tally_and_finish();
  end
endmodule
